/* asdp_regs.vh */
// constants for the serial data port of the eight-channel converter
// assumes a 25 MHz system clock and an AXI4-Lite master with 32-bit data
`ifndef ASDP_REGS_VH
`define ASDP_REGS_VH

// register byte offsets
`define ASDP_OFS_CONFIG  8'h00
`define ASDP_OFS_RESULT  8'h04
`define ASDP_OFS_CONTROL 8'h08
`define ASDP_OFS_STATUS  8'h0C

// config fields
`define ASDP_CFG_BIPOLAR 0
`define ASDP_CFG_RESET   1'h0

// result fields
`define ASDP_RES_W       12
`define ASDP_RES_RESET   12'h000

// control word: five bits, channel select in the top three
`define ASDP_CTRL_W      5
`define ASDP_CTRL_CH_LSB 2
`define ASDP_CTRL_RESET  5'h00

// status fields
`define ASDP_ST_RXBUSY   0
`define ASDP_ST_TXBUSY   1
`define ASDP_ST_PENDING  2
`define ASDP_ST_MASTER   3
`define ASDP_ST_RXCNT    8
`define ASDP_ST_CTCNT    16

// frame lengths in serial clock falling edges
`define ASDP_OUT_BITS    5'h10
`define ASDP_IN_BITS     3'h5

// synchroniser lanes
`define ASDP_SY_SCLK     0
`define ASDP_SY_RFS      1
`define ASDP_SY_TFS      2
`define ASDP_SY_DIN      3
`define ASDP_SY_CONV     4
`define ASDP_SY_MODE     5
`define ASDP_SY_W        6
`define ASDP_SY_RESET    6'h27

// bus answers
`define ASDP_RESP_OKAY   2'h0
`define ASDP_RESP_SLVERR 2'h2

`endif

/* asdp_serial_port.v */
// serial data port: result word out, control word in, AXI4-Lite registers
// assumes the serial clock, frame syncs, data input, conversion clock and
// mode pin come from outside the clk domain; two-way pins are split into
// input, output and active-low enable
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "asdp_regs.vh"

module asdp_serial_port (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  output wire [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  // mode and conversion clock pins
  input  wire        serialMasterSelect,
  input  wire        convClkIn,
  // serial clock pin
  input  wire        serialClkIn,
  output wire        serialClkOut,
  output wire        serialClkOeN,
  // receive frame sync pin
  input  wire        rxFrameSyncNIn,
  output wire        rxFrameSyncNOut,
  output wire        rxFrameSyncOeN,
  // transmit frame sync and data pins
  input  wire        txFrameSyncN,
  input  wire        dataIn,
  output wire        dataOut,
  output wire        dataOutOeN,
  // channel select to the analog multiplexer
  output wire        channelSelectBit0,
  output wire        channelSelectBit1,
  output wire        channelSelectBit2,
  output wire [4:0]  controlWord
);

  // byte-lane merge of a write into a register
  function [31:0] byteMerge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer      i;
    begin
      byteMerge = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          byteMerge[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  // true for an address that hits one of the four registers
  function isMapped;
    input [7:0] addr;
    begin
      isMapped = (addr[7:4] == 4'h0);
    end
  endfunction

  // pin synchronisers
  reg  [`ASDP_SY_W-1:0]  syncA_ff;
  reg  [`ASDP_SY_W-1:0]  syncB_ff;
  wire [`ASDP_SY_W-1:0]  pinsRaw;

  assign pinsRaw = {serialMasterSelect, convClkIn, dataIn,
                    txFrameSyncN, rxFrameSyncNIn, serialClkIn};

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      syncA_ff <= `ASDP_SY_RESET;
      syncB_ff <= `ASDP_SY_RESET;
    end else begin
      syncA_ff <= pinsRaw;
      syncB_ff <= syncA_ff;
    end
  end

  // register file state
  reg                    bipolar_ff;
  reg  [`ASDP_RES_W-1:0] result_ff;
  reg                    pending_ff;
  reg  [`ASDP_CTRL_W-1:0] ctrl_ff;
  reg  [7:0]             rxFrames_ff;
  reg  [7:0]             ctrlLoads_ff;

  // serial engine state
  reg                    sclkGen_ff;
  reg                    rfsGen_ff;
  reg                    sclkPrev_ff;
  reg                    convPrev_ff;
  reg                    rxPrev_ff;
  reg                    txPrev_ff;
  reg  [15:0]            shiftOut_ff;
  reg  [4:0]             outCnt_ff;
  reg                    dataOut_ff;
  reg                    dataOutOeN_ff;
  reg  [3:0]             shiftIn_ff;
  reg  [2:0]             inCnt_ff;

  wire masterMode = ~syncB_ff[`ASDP_SY_MODE];
  wire sclkLvl    = masterMode ? sclkGen_ff : syncB_ff[`ASDP_SY_SCLK];
  wire rxFrameN   = masterMode ? rfsGen_ff : syncB_ff[`ASDP_SY_RFS];
  wire txFrameN   = syncB_ff[`ASDP_SY_TFS];
  wire sclkFall   = sclkPrev_ff & ~sclkLvl;
  wire sclkRise   = ~sclkPrev_ff & sclkLvl;
  wire convRise   = ~convPrev_ff & syncB_ff[`ASDP_SY_CONV];
  wire rxStart    = rxPrev_ff & ~rxFrameN;
  wire txStart    = txPrev_ff & ~txFrameN;

  // bipolar range flips the sign bit of the offset-binary code
  wire [`ASDP_RES_W-1:0] codeOut = {result_ff[`ASDP_RES_W-1] ^ bipolar_ff,
                                    result_ff[`ASDP_RES_W-2:0]};
  wire [15:0]            wordOut = {1'b0, ctrl_ff[`ASDP_CTRL_W-1:`ASDP_CTRL_CH_LSB],
                                    codeOut};

  // edge history
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sclkPrev_ff <= 1'b1;
      convPrev_ff <= 1'b0;
      rxPrev_ff   <= 1'b1;
      txPrev_ff   <= 1'b1;
    end else begin
      sclkPrev_ff <= sclkLvl;
      convPrev_ff <= syncB_ff[`ASDP_SY_CONV];
      rxPrev_ff   <= rxFrameN;
      txPrev_ff   <= txFrameN;
    end
  end

  // master clock and frame generation
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sclkGen_ff <= 1'b1;
      rfsGen_ff  <= 1'b1;
    end else if (!masterMode) begin
      sclkGen_ff <= 1'b1;
      rfsGen_ff  <= 1'b1;
    end else if (convRise) begin
      sclkGen_ff <= ~sclkGen_ff;
      if (!sclkGen_ff) begin
        if (rfsGen_ff && pending_ff) begin
          rfsGen_ff <= 1'b0;
        end else if (!rfsGen_ff && outCnt_ff == `ASDP_OUT_BITS) begin
          rfsGen_ff <= 1'b1;
        end
      end
    end
  end

  // result word shifter
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      shiftOut_ff   <= 16'h0000;
      outCnt_ff     <= `ASDP_OUT_BITS;
      dataOut_ff    <= 1'b0;
      dataOutOeN_ff <= 1'b1;
      rxFrames_ff   <= 8'h00;
    end else begin
      dataOutOeN_ff <= rxFrameN;
      if (rxStart) begin
        shiftOut_ff <= wordOut;
        dataOut_ff  <= wordOut[15];
        outCnt_ff   <= 5'h00;
        rxFrames_ff <= rxFrames_ff + 8'h01;
      end else if (!rxFrameN) begin
        if (sclkFall && outCnt_ff != `ASDP_OUT_BITS) begin
          outCnt_ff <= outCnt_ff + 5'h01;
        end
        if (sclkRise && outCnt_ff != 5'h00 && outCnt_ff != `ASDP_OUT_BITS) begin
          shiftOut_ff <= {shiftOut_ff[14:0], 1'b0};
          dataOut_ff  <= shiftOut_ff[14];
        end
      end
    end
  end

  // control word capture
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      shiftIn_ff   <= 4'h0;
      inCnt_ff     <= `ASDP_IN_BITS;
      ctrl_ff      <= `ASDP_CTRL_RESET;
      ctrlLoads_ff <= 8'h00;
    end else if (txStart) begin
      inCnt_ff <= 3'h0;
    end else if (sclkFall && !txFrameN && inCnt_ff != `ASDP_IN_BITS) begin
      shiftIn_ff <= {shiftIn_ff[2:0], syncB_ff[`ASDP_SY_DIN]};
      inCnt_ff   <= inCnt_ff + 3'h1;
      if (inCnt_ff == `ASDP_IN_BITS - 3'h1) begin
        ctrl_ff      <= {shiftIn_ff, syncB_ff[`ASDP_SY_DIN]};
        ctrlLoads_ff <= ctrlLoads_ff + 8'h01;
      end
    end
  end

  // AXI4-Lite slave
  reg        awHeld_ff;
  reg  [7:0] awAddr_ff;
  reg        wHeld_ff;
  reg [31:0] wData_ff;
  reg  [3:0] wStrb_ff;
  reg        bvalid_ff;
  reg  [1:0] bresp_ff;
  reg        rvalid_ff;
  reg [31:0] rdata_ff;
  reg  [1:0] rresp_ff;
  reg [31:0] readMux;
  wire       doWrite     = awHeld_ff & wHeld_ff & ~bvalid_ff;
  wire       resultWrite = doWrite & (awAddr_ff == `ASDP_OFS_RESULT);
  wire [31:0] cfgMerged  = byteMerge({31'h00000000, bipolar_ff}, wData_ff, wStrb_ff);
  wire [31:0] resMerged  = byteMerge({20'h00000, result_ff}, wData_ff, wStrb_ff);

  assign s_axi_awready = ~awHeld_ff & ~bvalid_ff;
  assign s_axi_wready  = ~wHeld_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always @* begin
    readMux = 32'h00000000;
    case ({s_axi_araddr[7:2], 2'h0})
      `ASDP_OFS_CONFIG:  readMux[`ASDP_CFG_BIPOLAR] = bipolar_ff;
      `ASDP_OFS_RESULT:  readMux[`ASDP_RES_W-1:0] = result_ff;
      `ASDP_OFS_CONTROL: readMux[`ASDP_CTRL_W-1:0] = ctrl_ff;
      `ASDP_OFS_STATUS: begin
        readMux[`ASDP_ST_RXBUSY]    = ~rxFrameN;
        readMux[`ASDP_ST_TXBUSY]    = ~txFrameN;
        readMux[`ASDP_ST_PENDING]   = pending_ff;
        readMux[`ASDP_ST_MASTER]    = masterMode;
        readMux[`ASDP_ST_RXCNT +: 8] = rxFrames_ff;
        readMux[`ASDP_ST_CTCNT +: 8] = ctrlLoads_ff;
      end
      default: readMux = 32'h00000000;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeld_ff  <= 1'b0;
      awAddr_ff  <= 8'h00;
      wHeld_ff   <= 1'b0;
      wData_ff   <= 32'h00000000;
      wStrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `ASDP_RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `ASDP_RESP_OKAY;
      bipolar_ff <= `ASDP_CFG_RESET;
      result_ff  <= `ASDP_RES_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= isMapped(awAddr_ff) ? `ASDP_RESP_OKAY : `ASDP_RESP_SLVERR;
        if (awAddr_ff == `ASDP_OFS_CONFIG) begin
          bipolar_ff <= cfgMerged[`ASDP_CFG_BIPOLAR];
        end
        if (awAddr_ff == `ASDP_OFS_RESULT) begin
          result_ff <= resMerged[`ASDP_RES_W-1:0];
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= readMux;
        rresp_ff  <= isMapped(s_axi_araddr) ? `ASDP_RESP_OKAY : `ASDP_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // a fresh result write wins over the frame that consumes the old one
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pending_ff <= 1'b0;
    end else if (resultWrite) begin
      pending_ff <= 1'b1;
    end else if (rxStart) begin
      pending_ff <= 1'b0;
    end
  end

  // pin drive; enables are low while driving
  assign serialClkOut    = sclkGen_ff;
  assign serialClkOeN    = ~masterMode;
  assign rxFrameSyncNOut = rfsGen_ff;
  assign rxFrameSyncOeN  = ~masterMode;
  assign dataOut         = dataOut_ff;
  assign dataOutOeN      = dataOutOeN_ff;

  // channel routing to the multiplexer
  assign channelSelectBit0 = ctrl_ff[`ASDP_CTRL_CH_LSB];
  assign channelSelectBit1 = ctrl_ff[`ASDP_CTRL_CH_LSB + 1];
  assign channelSelectBit2 = ctrl_ff[`ASDP_CTRL_CH_LSB + 2];
  assign controlWord       = ctrl_ff;

endmodule

/* asdp_monitor.sv */
// assertions on the serial port pins and bus answers
// assumes it is bound to asdp_serial_port
`timescale 1ns/1ns
module asdp_monitor (
  // clock, reset, bus answers
  input wire        clk,
  input wire        reset,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // link pins and control word
  input wire        serialMasterSelect,
  input wire        convClkIn,
  input wire        serialClkIn,
  input wire        serialClkOut,
  input wire        serialClkOeN,
  input wire        rxFrameSyncNIn,
  input wire        rxFrameSyncNOut,
  input wire        rxFrameSyncOeN,
  input wire        txFrameSyncN,
  input wire        dataOut,
  input wire        dataOutOeN,
  input wire        channelSelectBit0,
  input wire        channelSelectBit1,
  input wire        channelSelectBit2,
  input wire [4:0]  controlWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire      sck = serialClkOeN ? serialClkIn : serialClkOut;
  wire      rx_frame_sync_n = rxFrameSyncOeN ? rxFrameSyncNIn : rxFrameSyncNOut;
  reg [4:0] falls_ff;
  reg [2:0] convAge_ff;
  // serial clock falls inside a transmit frame, cycles since a conversion clock rise
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      falls_ff <= 5'h00;
      convAge_ff <= 3'h0;
    end else begin
      falls_ff <= txFrameSyncN ? 5'h00 : falls_ff + {4'h0, $fell(sck)};
      convAge_ff <= $rose(convClkIn) ? 3'h0 : convAge_ff + {2'h0, convAge_ff != 3'h7};
    end
  end
  sequence s_modeLow;
    !serialMasterSelect [*6];
  endsequence
  sequence s_modeHigh;
    serialMasterSelect [*6];
  endsequence
  a_master_drives: assert property (s_modeLow |-> !serialClkOeN && !rxFrameSyncOeN)
    else $error("master mode pins not driven");
  a_slave_listens: assert property (s_modeHigh |-> serialClkOeN && rxFrameSyncOeN)
    else $error("slave mode pins driven");
  a_master_clock: assert property (!serialClkOeN && $changed(serialClkOut) |-> convAge_ff < 3'h6)
    else $error("serial clock not led by conversion clock");
  a_load_fifth: assert property ($changed(controlWord) |-> falls_ff == 5'h05)
    else $error("control word loaded off the fifth bit");
  a_channel_bits: assert property ({channelSelectBit2, channelSelectBit1, channelSelectBit0} == controlWord[4:2])
    else $error("channel select differs from control word");
  a_lead_zero: assert property ($fell(dataOutOeN) |-> !dataOut && !rx_frame_sync_n)
    else $error("word does not start with zero inside a frame");
  a_release_after: assert property ($rose(rx_frame_sync_n) |-> ##[1:6] dataOutOeN)
    else $error("data output not released after frame");
  a_bresp_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_rdata_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule
bind asdp_serial_port asdp_monitor i_asdp_monitor (.*);

/* asdp_host_model.sv */
// host serial port: clock idling high, one frame sync for both directions
// assumes both frame sync pins of the device are tied to frameN
`timescale 1ns/1ns
module asdp_host_model (
  // clock
  input wire   clk,
  // link pins
  output logic sclk,
  output logic frameN,
  output logic dIn,
  input wire   dOut,
  input wire   dOutOeN
);
  initial begin
    sclk = 1'b1;
    frameN = 1'b1;
    dIn = 1'b0;
  end
  // data line keeps changing outside frames
  always @(posedge clk) if (frameN) dIn <= ~dIn;
  task automatic xfer(input logic [4:0] c, output logic [15:0] r);
    frameN <= 1'b0;
    @(posedge clk);
    dIn <= c[4];
    repeat (7) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      r[15-i] = dOutOeN ? 1'bx : dOut;
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      dIn <= (i < 4) ? c[3-i] : ~dIn;
      repeat (4) @(posedge clk);
    end
    frameN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* test_adc_serial_data_port.sv */
// bench: bus tasks, slave frames through the host model, one master frame
// assumes the register map of asdp_regs.vh
`timescale 1ns/1ns
`include "asdp_regs.vh"
module test_adc_serial_data_port;
  logic        clk = 1'b0, reset = 1'b1, mode = 1'b1, conv = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  wire         awready, wready, bvalid, arready, rvalid, sclkOut, sclkOeN, rfsOut, rfsOeN;
  wire         dataOut, dataOeN, cs0, cs1, cs2, hSclk, hFrameN, hData;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [4:0]   ctrl;
  wire         sclkW = sclkOeN ? hSclk : sclkOut;
  wire         rfsW = rfsOeN ? hFrameN : rfsOut;
  int          mismatches = 0, samples_checked = 0;
  localparam logic [11:0] codeTab [8] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF,
                                          12'h5A5, 12'hA5A, 12'h001, 12'h3C3};
  asdp_serial_port i_asdp_serial_port (
    .clk(clk), .reset(reset),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .serialMasterSelect(mode), .convClkIn(conv),
    .serialClkIn(sclkW), .serialClkOut(sclkOut), .serialClkOeN(sclkOeN),
    .rxFrameSyncNIn(rfsW), .rxFrameSyncNOut(rfsOut), .rxFrameSyncOeN(rfsOeN),
    .txFrameSyncN(hFrameN), .dataIn(hData), .dataOut(dataOut), .dataOutOeN(dataOeN),
    .channelSelectBit0(cs0), .channelSelectBit1(cs1), .channelSelectBit2(cs2),
    .controlWord(ctrl));
  asdp_host_model i_asdp_host_model (.clk(clk), .sclk(hSclk), .frameN(hFrameN),
    .dIn(hData), .dOut(dataOut), .dOutOeN(dataOeN));
  always #20 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    conv <= ~conv;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bus waits have no limit of their own; the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, r});
    chk(rdata, e);
  endtask
  task end_of_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #400000;
    mismatches++;
    end_of_test;
  end
  initial begin
    logic [15:0] r;
    logic [4:0]  c, pc;
    int          n, cnt;
    logic        ps;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(`ASDP_OFS_CONFIG, 32'h0, `ASDP_RESP_OKAY);
    rd(`ASDP_OFS_CONTROL, 32'h0, `ASDP_RESP_OKAY);
    rd(8'h40, 32'h0, `ASDP_RESP_SLVERR);
    wr(8'h40, 32'h1, `ASDP_RESP_SLVERR);
    pc = 5'h00;
    for (int k = 0; k < 8; k++) begin
      c = {k[2:0], k[1], ~k[0]};
      wr(`ASDP_OFS_CONFIG, {31'h0, k[0]}, `ASDP_RESP_OKAY);
      wr(`ASDP_OFS_RESULT, {20'h0, codeTab[k]}, `ASDP_RESP_OKAY);
      i_asdp_host_model.xfer(c, r);
      chk({16'h0, r}, {17'h0, pc[4:2], codeTab[k] ^ {k[0], 11'h0}});
      chk({27'h0, ctrl}, {27'h0, c});
      chk({29'h0, cs2, cs1, cs0}, {29'h0, c[4:2]});
      rd(`ASDP_OFS_CONTROL, {27'h0, c}, `ASDP_RESP_OKAY);
      pc = c;
    end
    wr(`ASDP_OFS_CONTROL, 32'h1F, `ASDP_RESP_OKAY);
    wr(`ASDP_OFS_CONFIG, 32'h0, `ASDP_RESP_OKAY);
    wr(`ASDP_OFS_RESULT, 32'hABC, `ASDP_RESP_OKAY);
    rd(`ASDP_OFS_RESULT, 32'hABC, `ASDP_RESP_OKAY);
    rd(`ASDP_OFS_STATUS, (32'h1 << `ASDP_ST_PENDING) | (32'h8 << `ASDP_ST_RXCNT) |
       (32'h8 << `ASDP_ST_CTCNT), `ASDP_RESP_OKAY);
    rd(`ASDP_OFS_CONTROL, {27'h0, pc}, `ASDP_RESP_OKAY);
    mode <= 1'b0;
    n = 0;
    cnt = 0;
    ps = 1'b1;
    while (cnt < 16 && n < 3000) begin
      @(posedge clk);
      n++;
      if (ps && !sclkOut && !rfsOut) begin
        r = {r[14:0], dataOut};
        cnt++;
      end
      ps = sclkOut;
    end
    chk({31'h0, cnt == 16}, 32'h1);
    chk({16'h0, r}, {17'h0, pc[4:2], 12'hABC});
    chk({30'h0, sclkOeN, rfsOeN}, 32'h0);
    // frame still open: receive busy, master, nine frames, eight loads
    rd(`ASDP_OFS_STATUS, (32'h1 << `ASDP_ST_RXBUSY) | (32'h1 << `ASDP_ST_MASTER) |
       (32'h9 << `ASDP_ST_RXCNT) | (32'h8 << `ASDP_ST_CTCNT), `ASDP_RESP_OKAY);
    end_of_test;
  end
endmodule
